// ==== shared/adc_ctrl_defs.vh ====
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH
// register placement
// the printed offset is a word index; the byte address is four times it
`define CTRL_REG_INDEX    15'h54a2
`define CTRL_REG_ADDR     17'h15288
// bits that are implemented: 14:12, 10, 1, 0
`define CTRL_RD_MASK      16'h7403
// field positions
`define MOD_CLK_EN_BIT    0
`define CONV_START_BIT    1
`define CONV_BUSY_BIT     10
`define CONV_STAT_LSB     12
`define CONV_STAT_MSB     14
// reset values
`define CONV_STAT_RST     3'h0
`define CONV_BUSY_RST     1'h0
`define CTRL_BIT_RST      1'h0
// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ==== hdl/adc_control_register.v ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

// Overview of operation
// - the control register is placed at word index 0x54a2 of the register map (byte address 0x15288).
// - the busy flag is a read-only bit 10 that resets to 0.
// - the busy flag reads 1 during a conversion and 0 while idle.
// - writing 0 to the module clock enable clears the busy flag.
// - the three-bit read-only status field sits in bits 14 to 12 and resets to 0.
// - start is bit 1 and clock enable bit 0, both read/write and reset to 0.
// - unused bits read zero and ignore writes.
module adc_control_register (
    // clock and reset
    input  wire        CLK_IN,
    input  wire        RESETN_IN,
    // axi4-lite write
    input  wire [16:0] AWADDR_IN,
    input  wire        AWVALID_IN,
    output wire        AWREADY_OUT,
    input  wire [31:0] WDATA_IN,
    input  wire [3:0]  WSTRB_IN,
    input  wire        WVALID_IN,
    output wire        WREADY_OUT,
    output reg  [1:0]  BRESP_OUT,
    output reg         BVALID_OUT,
    input  wire        BREADY_IN,
    // axi4-lite read
    input  wire [16:0] ARADDR_IN,
    input  wire        ARVALID_IN,
    output wire        ARREADY_OUT,
    output reg  [31:0] RDATA_OUT,
    output reg  [1:0]  RRESP_OUT,
    output reg         RVALID_OUT,
    input  wire        RREADY_IN,
    // converter core
    input  wire        CONV_DONE_IN,
    input  wire [2:0]  CONV_STATUS_IN,
    output wire        CONV_CLK_EN_OUT,
    output reg         CONV_START_OUT
);
    // reset release
    reg         rst_m_q;
    reg         rst_s_q;
    wire        rst_n;

    // write channel capture
    reg         aw_got_q;
    reg  [16:0] aw_addr_q;
    reg         w_got_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    // register fields
    reg         clk_en_q;
    reg         start_q;
    reg         busy_q;
    reg  [2:0]  stat_q;

    // decode
    wire [14:0] ctrl_index;
    wire        wr_go;
    wire        wr_hit;
    wire        wr_apply;
    wire        rd_hit;
    wire [15:0] wr_half;
    wire        new_en;
    wire        new_start;
    wire        conv_go;
    wire [15:0] reg_val;
    wire [15:0] rd_mask;
    wire [31:0] rd_word;

    // assertion is asynchronous, release goes through two flops
    always @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end
    assign rst_n = rst_s_q;

    // the register is a 16-bit word at index 0x54a2, i.e. byte address four times that
    assign ctrl_index = `CTRL_REG_INDEX;
    // address and data are latched independently, so either may come first
    assign AWREADY_OUT = rst_n && !aw_got_q && !BVALID_OUT;
    assign WREADY_OUT  = rst_n && !w_got_q && !BVALID_OUT;
    assign ARREADY_OUT = rst_n && !RVALID_OUT;
    assign wr_go    = aw_got_q && w_got_q && !BVALID_OUT;
    assign wr_hit   = (aw_addr_q[16:2] == ctrl_index);
    // a miss answers slverr with zero data
    assign rd_hit   = (ARADDR_IN[16:2] == ctrl_index);
    // only byte lane 0 holds writable bits
    assign wr_apply = wr_go && wr_hit && w_strb_q[0];
    assign wr_half  = w_data_q[15:0];
    assign new_en    = wr_apply ? wr_half[`MOD_CLK_EN_BIT] : clk_en_q;
    assign new_start = wr_apply ? wr_half[`CONV_START_BIT] : start_q;
    // start is ignored while busy or while the clock is off
    assign conv_go   = wr_apply && new_en && clk_en_q && new_start && !busy_q;

    // bits 15, 11, 9:2 are not stored and read zero
    assign reg_val = {1'b0, stat_q, 1'b0, busy_q, 8'h00, start_q, clk_en_q};
    assign rd_mask = `CTRL_RD_MASK;
    assign CONV_CLK_EN_OUT = clk_en_q;

    // upper half-word and unused bits are masked per bit
    genvar b;
    generate
        for (b = 0; b < 32; b = b + 1) begin : g_rd
            if (b < 16) begin : g_lo
                assign rd_word[b] = reg_val[b] & rd_mask[b];
            end else begin : g_hi
                assign rd_word[b] = 1'b0;
            end
        end
    endgenerate

    // a write waits until both address and data are held
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= 17'h00000;
            w_got_q   <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
            end else begin
                if (AWVALID_IN && AWREADY_OUT) begin
                    aw_got_q  <= 1'b1;
                    aw_addr_q <= AWADDR_IN;
                end
                if (WVALID_IN && WREADY_OUT) begin
                    w_got_q  <= 1'b1;
                    w_data_q <= WDATA_IN;
                    w_strb_q <= WSTRB_IN;
                end
            end
        end
    end

    // write response stands until the master takes it
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            BVALID_OUT <= 1'b0;
            BRESP_OUT  <= `RESP_OKAY;
        end else if (wr_go) begin
            BVALID_OUT <= 1'b1;
            BRESP_OUT  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (BVALID_OUT && BREADY_IN) begin
            BVALID_OUT <= 1'b0;
        end
    end

    // read data is captured at the address handshake and held with rvalid
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            RVALID_OUT <= 1'b0;
            RRESP_OUT  <= `RESP_OKAY;
            RDATA_OUT  <= 32'h0000_0000;
        end else if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RDATA_OUT  <= rd_hit ? rd_word : 32'h0000_0000;
            RRESP_OUT  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (RVALID_OUT && RREADY_IN) begin
            RVALID_OUT <= 1'b0;
        end
    end

    // status field follows the converter one cycle late
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= `CONV_STAT_RST;
        end else begin
            stat_q <= CONV_STATUS_IN;
        end
    end

    // enable, start and busy
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            clk_en_q <= `CTRL_BIT_RST;
            start_q  <= `CTRL_BIT_RST;
            busy_q   <= `CONV_BUSY_RST;
        end else begin
            clk_en_q <= new_en;
            if (new_en && !clk_en_q) begin
                // a start in the same write as the enable is dropped
                busy_q  <= 1'b0;
                start_q <= 1'b0;
            end else if (!new_en) begin
                // with no clock the converter cannot run
                busy_q  <= 1'b0;
                start_q <= new_start;
            end else if (conv_go) begin
                busy_q  <= 1'b1;
                start_q <= 1'b1;
            end else if (busy_q && CONV_DONE_IN) begin
                busy_q  <= 1'b0;
                start_q <= 1'b0;
            end else begin
                start_q <= busy_q ? start_q : new_start;
            end
        end
    end

    // one-cycle start pulse to the converter
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            CONV_START_OUT <= 1'b0;
        end else begin
            CONV_START_OUT <= conv_go;
        end
    end
endmodule // adc_control_register
`default_nettype wire

// ==== test/adc_control_register_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_reg_chk (
    input wire logic        CLK_IN, RESETN_IN, ARVALID_IN, ARREADY_OUT, RVALID_OUT,
    input wire logic        RREADY_IN, BVALID_OUT, BREADY_IN, CONV_CLK_EN_OUT, CONV_START_OUT,
    input wire logic [1:0]  BRESP_OUT,
    input wire logic [31:0] RDATA_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence go_s; CONV_START_OUT ##1 !CONV_START_OUT; endsequence
    hi_lane_a: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0000)
        else $error("high lane");
    gap_bits_a: assert property (RVALID_OUT |-> RDATA_OUT[9:2] == 8'h00 && !RDATA_OUT[11]
        && !RDATA_OUT[15]) else $error("gap bits");
    busy_en_a: assert property (RVALID_OUT && RDATA_OUT[10] |-> RDATA_OUT[0])
        else $error("busy off");
    rd_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
        else $error("rdata");
    wr_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("bresp");
    rd_answer_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT) else $error("ar");
    go_pulse_a: assert property (CONV_START_OUT |-> go_s) else $error("pulse");
    go_en_a: assert property (CONV_START_OUT |-> CONV_CLK_EN_OUT) else $error("go off");
endmodule // adc_reg_chk
bind adc_control_register adc_reg_chk chk (.*);
`default_nettype wire

// ==== test/adc_control_register_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"
module adc_control_register_test;
    localparam logic [16:0] A = `CTRL_REG_ADDR;
    localparam logic [1:0] OK = `RESP_OKAY, ER = `RESP_SLVERR;
    logic CLK_IN = 0, RESETN_IN = 0, AWVALID_IN = 0, WVALID_IN = 0, BREADY_IN = 0;
    logic ARVALID_IN = 0, RREADY_IN = 0, CONV_DONE_IN = 0, AWREADY_OUT, WREADY_OUT;
    logic BVALID_OUT, ARREADY_OUT, RVALID_OUT, CONV_CLK_EN_OUT, CONV_START_OUT;
    logic [16:0] AWADDR_IN = 0, ARADDR_IN = 0;
    logic [31:0] WDATA_IN = 0, RDATA_OUT;
    logic [3:0]  WSTRB_IN = 0;
    logic [2:0]  CONV_STATUS_IN = 0;
    logic [1:0]  BRESP_OUT, RRESP_OUT;
    integer      n_fail = 0, num_checks = 0, en = 0, bz = 0, i;
    adc_control_register dut (.*);
    always #20 CLK_IN = ~CLK_IN;
    // start reads back with busy, so one model bit serves both
    function logic [31:0] rv();
        return {16'h0, 1'b0, CONV_STATUS_IN, 1'b0, bz[0], 8'h0, bz[0], en[0]};
    endfunction
    task chk(input string s, input logic [33:0] e, g);
        num_checks++;
        if (g !== e) begin n_fail++; $display("unexpected %s exp %h got %h", s, e, g); end
    endtask
    task bus(input logic w, input logic [3:0] s, input logic [16:0] a,
             input logic [31:0] v, input logic [1:0] r);
        @(posedge CLK_IN);
        AWADDR_IN <= a; ARADDR_IN <= a; WDATA_IN <= v; WSTRB_IN <= s;
        AWVALID_IN <= w; WVALID_IN <= w; BREADY_IN <= w; ARVALID_IN <= !w; RREADY_IN <= !w;
        forever begin
            @(posedge CLK_IN);
            if (AWREADY_OUT) AWVALID_IN <= 0;
            if (WREADY_OUT) WVALID_IN <= 0;
            if (ARREADY_OUT) ARVALID_IN <= 0;
            if (BVALID_OUT || RVALID_OUT) break;
        end
        BREADY_IN <= 0;
        RREADY_IN <= 0;
        if (w) chk("bresp", r, BRESP_OUT);
        else chk("read", {r, v}, {RRESP_OUT, RDATA_OUT});
    endtask
    initial begin
        void'($urandom(99));
        repeat (4) @(posedge CLK_IN);
        RESETN_IN <= 1;
        repeat (2) @(posedge CLK_IN);
        bus(0, 0, A, 0, OK);
        bus(1, 4'hf, A + 17'h4, 32'h1, ER);
        bus(0, 0, A + 17'h4, 0, ER);
        bus(0, 0, A, 0, OK);
        for (i = 0; i < 8; i++) begin
            CONV_STATUS_IN <= 3'($urandom);
            en = $urandom & 1;
            bus(1, 4'hf, A, ($urandom & 32'hffff_fffc) | en, OK);
            chk("clk_en", en, CONV_CLK_EN_OUT);
            bus(0, 0, A, rv(), OK);
        end
        en = 1;
        bus(1, 4'hf, A, 32'h1, OK);
        bus(1, 4'hc, A, 0, OK);
        bz = 1;
        bus(1, 4'hf, A, 32'h3, OK);
        chk("start_pulse", 1, CONV_START_OUT);
        bus(0, 0, A, rv(), OK);
        CONV_DONE_IN <= 1;
        @(posedge CLK_IN);
        CONV_DONE_IN <= 0;
        bz = 0;
        bus(0, 0, A, rv(), OK);
        end_sim;
    end
    task end_sim;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin #100000; n_fail++; end_sim; end
endmodule // adc_control_register_test
`default_nettype wire
